// ===== rtl/asrs_pkg.sv
// Constants for the analog speed reference scaler.
// Frequencies are in 0.1 Hz steps, analog inputs in 0.1 % steps.
package asrs_pkg;
  localparam int ADDR_W = 8;
  localparam int FW = 12;
  localparam int XW = 10;
  localparam int PW = 7;
  localparam int AW = 17;
  localparam int CW = 5;
  // ----------------------------------------
  // Register byte offsets
  // ----------------------------------------
  localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_BASE1 = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_MAX1 = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_BASE2 = 8'h0C;
  localparam logic [ADDR_W-1:0] OFF_MAX2 = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_SRC = 8'h14;
  localparam logic [ADDR_W-1:0] OFF_VSF = 8'h18;
  localparam logic [ADDR_W-1:0] OFF_VEF = 8'h1C;
  localparam logic [ADDR_W-1:0] OFF_VSP = 8'h20;
  localparam logic [ADDR_W-1:0] OFF_VEP = 8'h24;
  localparam logic [ADDR_W-1:0] OFF_VLOW = 8'h28;
  localparam logic [ADDR_W-1:0] OFF_AVG = 8'h2C;
  localparam logic [ADDR_W-1:0] OFF_ISF = 8'h30;
  localparam logic [ADDR_W-1:0] OFF_IEF = 8'h34;
  localparam logic [ADDR_W-1:0] OFF_ISP = 8'h38;
  localparam logic [ADDR_W-1:0] OFF_IEP = 8'h3C;
  localparam logic [ADDR_W-1:0] OFF_ILOW = 8'h40;
  localparam logic [ADDR_W-1:0] OFF_FREQ = 8'h44;
  localparam logic [ADDR_W-1:0] OFF_VOLT = 8'h48;
  // ----------------------------------------
  // Limits and reset values
  // ----------------------------------------
  localparam logic [FW-1:0] BASE_MIN = 12'h12C;
  localparam logic [FW-1:0] FREQ_LIM = 12'hFA0;
  localparam logic [PW-1:0] PCT_MAX = 7'h64;
  localparam logic [XW-1:0] PCT_SCALE = 10'h00A;
  localparam logic [XW-1:0] VOLT_FULL = 10'h3E8;
  localparam logic [XW-1:0] KNOB_FULL = 10'h3E8;
  localparam logic [CW-1:0] AVG_MIN = 5'h01;
  localparam logic [CW-1:0] AVG_MAX = 5'h11;
  localparam logic [CW-1:0] AVG_RST = 5'h08;
  localparam logic [FW-1:0] BASE_RST = 12'h1F4;
  localparam logic [FW-1:0] MAX_RST = 12'h1F4;
  localparam logic [PW-1:0] EP_RST = 7'h64;
  localparam logic LOW_RST = 1'b1;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [2:0] {
    SRC_V_KNOB = 3'b010,
    SRC_I_KNOB = 3'b011,
    SRC_V_ONLY = 3'b100,
    SRC_I_ONLY = 3'b101
  } asrs_src_e;
endpackage

// ===== rtl/asrs_seg_map.sv
// Linear segment map from an analog reading to a frequency.
// Purely combinational; the caller registers the result.
`timescale 1ns/1ps
`default_nettype none
module asrs_seg_map
  import asrs_pkg::*;
(
  input wire logic [XW-1:0] x,
  input wire logic [PW-1:0] sp,
  input wire logic [PW-1:0] ep,
  input wire logic [FW-1:0] sf,
  input wire logic [FW-1:0] ef,
  input wire logic low_zero,
  output logic [FW-1:0] f
);
  logic [XW-1:0] xs, xe, span, dx;
  logic signed [12:0] df;
  logic signed [23:0] prod, quot;
  logic signed [24:0] sum;

  always_comb
  begin
    xs = XW'({3'h0, sp} * PCT_SCALE);
    xe = XW'({3'h0, ep} * PCT_SCALE);
    span = (xe > xs) ? XW'(xe - xs) : 10'h001;
    dx = XW'(x - xs);
    df = $signed({1'b0, ef}) - $signed({1'b0, sf});
    prod = df * $signed({1'b0, dx});
    quot = prod / $signed({14'h000, span});
    sum = 25'(quot) + 25'($signed({1'b0, sf}));
    // RULE_08 RULE_11 below start point
    if (x < xs)
    begin
      f = low_zero ? 12'h000 : sf;
    end
    // RULE_09 RULE_12 above end point
    else if (x >= xe)
    begin
      f = ef;
    end
    else
    begin
      f = sum[FW-1:0];
    end
  end
endmodule
`default_nettype wire

// ===== rtl/asrs_top.sv
// Analog speed reference scaler with AXI4-Lite register access.
// Samples arrive with a strobe from same-clock converter logic.
// What this block does
// RULE_01 - Base frequency write accepted only from 30 Hz up to maximum.
// RULE_02 - Maximum frequency write accepted only from base up to 400 Hz.
// RULE_03 - Output voltage rises with frequency at fixed V/f up to base.
// RULE_04 - From base to maximum frequency output voltage stays at full scale.
// RULE_05 - Voltage and current inputs are never used together.
// RULE_06 - Voltage input maps linearly between start and end points.
// RULE_07 - Start and end frequencies accepted only within 0 to 400 Hz.
// RULE_08 - Voltage below start point gives 0 Hz or start frequency.
// RULE_09 - Voltage above end point gives the end frequency.
// RULE_10 - Current input has its own independent linear map.
// RULE_11 - Current below start point gives 0 Hz or its start frequency.
// RULE_12 - Current above end point gives its end frequency.
// RULE_13 - Selection code picks voltage, current or knob source.
// RULE_14 - Reference is averaged over 1 to 17 samples, default 8.
// RULE_15 - A second base and maximum set can drive the output.
// RULE_16 - Final frequency never exceeds the active maximum; freq_cmd stays above it for one cycle after the active maximum drops.
//
// The register offsets and the AXI4-Lite register port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module asrs_top
  import asrs_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic sample_strobe,
  input wire logic [XW-1:0] voltage_in_code,
  input wire logic [XW-1:0] current_in_terminal,
  input wire logic [XW-1:0] front_knob,
  input wire logic input_select_pin,
  output logic [FW-1:0] freq_cmd,
  output logic [XW-1:0] volt_cmd
);
  typedef struct packed {
    logic aw_hold;
    logic [ADDR_W-1:0] aw_addr;
    logic w_hold;
    logic [31:0] w_data;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic set2;
    logic [FW-1:0] base1;
    logic [FW-1:0] max1;
    logic [FW-1:0] base2;
    logic [FW-1:0] max2;
    logic [2:0] src;
    logic [FW-1:0] vsf;
    logic [FW-1:0] vef;
    logic [PW-1:0] vsp;
    logic [PW-1:0] vep;
    logic vlow;
    logic [CW-1:0] avg_n;
    logic [FW-1:0] isf;
    logic [FW-1:0] ief;
    logic [PW-1:0] isp;
    logic [PW-1:0] iep;
    logic ilow;
    logic [AW-1:0] acc;
    logic [CW-1:0] cnt;
    logic [FW-1:0] freq;
    logic [XW-1:0] volt;
    logic sel_meta;
    logic sel_sync;
  } asrs_state_s;

  asrs_state_s st_reg, st_next;
  logic [FW-1:0] vmap, imap, knob_f, pick, act_base, act_max, avg_f;
  logic [AW-1:0] acc_sum, avg_q;
  logic [21:0] knob_p, volt_p;
  logic [XW-1:0] volt_calc;
  logic wr_go, wr_ok;
  logic [31:0] rd_val;
  logic rd_hit;

  // ----------------------------------------
  // Source maps
  // ----------------------------------------
  // RULE_06 voltage segment map
  asrs_seg_map u_vmap (
    .x(voltage_in_code),
    .sp(st_reg.vsp),
    .ep(st_reg.vep),
    .sf(st_reg.vsf),
    .ef(st_reg.vef),
    .low_zero(st_reg.vlow),
    .f(vmap)
  );
  // RULE_10 independent current map
  asrs_seg_map u_imap (
    .x(current_in_terminal),
    .sp(st_reg.isp),
    .ep(st_reg.iep),
    .sf(st_reg.isf),
    .ef(st_reg.ief),
    .low_zero(st_reg.ilow),
    .f(imap)
  );

  assign s_axi_awready = !st_reg.aw_hold;
  assign s_axi_wready = !st_reg.w_hold;
  assign s_axi_arready = !st_reg.rvalid;
  assign s_axi_bvalid = st_reg.bvalid;
  assign s_axi_bresp = st_reg.bresp;
  assign s_axi_rvalid = st_reg.rvalid;
  assign s_axi_rresp = st_reg.rresp;
  assign s_axi_rdata = st_reg.rdata;
  assign freq_cmd = st_reg.freq;
  assign volt_cmd = st_reg.volt;

  always_comb
  begin
    st_next = st_reg;
    // RULE_15 active parameter set
    act_base = st_reg.set2 ? st_reg.base2 : st_reg.base1;
    act_max = st_reg.set2 ? st_reg.max2 : st_reg.max1;
    knob_p = 22'(front_knob) * 22'(act_max);
    knob_f = FW'(knob_p / 22'(KNOB_FULL));
    // RULE_13 source selection
    // RULE_05 one analog input only
    case (st_reg.src)
      SRC_V_KNOB: pick = st_reg.sel_sync ? vmap : knob_f;
      SRC_I_KNOB: pick = st_reg.sel_sync ? imap : knob_f;
      SRC_I_ONLY: pick = imap;
      default: pick = vmap;
    endcase
    // ----------------------------------------
    // Averaging and clamp
    // ----------------------------------------
    acc_sum = AW'(st_reg.acc + AW'(pick));
    avg_q = acc_sum / AW'(st_reg.avg_n);
    avg_f = avg_q[FW-1:0];
    if (sample_strobe)
    begin
      // RULE_14 block average of n samples
      if (st_reg.cnt + 5'h01 >= st_reg.avg_n)
      begin
        st_next.acc = '0;
        st_next.cnt = '0;
        st_next.freq = avg_f;
      end
      else
      begin
        st_next.acc = acc_sum;
        st_next.cnt = CW'(st_reg.cnt + 5'h01);
      end
    end
    // RULE_16 clamp to active maximum
    if (st_next.freq > act_max)
    begin
      st_next.freq = act_max;
    end
    // RULE_03 constant V/f below base
    volt_p = 22'(st_reg.freq) * 22'(VOLT_FULL);
    volt_calc = XW'(volt_p / 22'(act_base));
    // RULE_04 full scale above base
    if (st_reg.freq >= act_base)
    begin
      volt_calc = VOLT_FULL;
    end
    st_next.volt = volt_calc;
    st_next.sel_meta = input_select_pin;
    st_next.sel_sync = st_reg.sel_meta;
    // ----------------------------------------
    // Write channel
    // ----------------------------------------
    if (s_axi_awvalid && !st_reg.aw_hold)
    begin
      st_next.aw_hold = 1'b1;
      st_next.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !st_reg.w_hold)
    begin
      st_next.w_hold = 1'b1;
      st_next.w_data = s_axi_wdata;
    end
    if (st_reg.bvalid && s_axi_bready)
    begin
      st_next.bvalid = 1'b0;
    end
    wr_go = st_reg.aw_hold && st_reg.w_hold && !st_reg.bvalid;
    wr_ok = 1'b0;
    if (st_reg.aw_addr == OFF_CTRL)
    begin
      wr_ok = 1'b1;
    end
    else if (st_reg.aw_addr == OFF_BASE1)
    begin
      // RULE_01 base range check
      wr_ok = st_reg.w_data[31:FW] == '0 && st_reg.w_data[FW-1:0] >= BASE_MIN &&
        st_reg.w_data[FW-1:0] <= st_reg.max1;
    end
    else if (st_reg.aw_addr == OFF_MAX1)
    begin
      // RULE_02 maximum range check
      wr_ok = st_reg.w_data[31:FW] == '0 && st_reg.w_data[FW-1:0] <= FREQ_LIM &&
        st_reg.w_data[FW-1:0] >= st_reg.base1;
    end
    else if (st_reg.aw_addr == OFF_BASE2)
    begin
      // RULE_01 second base check
      wr_ok = st_reg.w_data[31:FW] == '0 && st_reg.w_data[FW-1:0] >= BASE_MIN &&
        st_reg.w_data[FW-1:0] <= st_reg.max2;
    end
    else if (st_reg.aw_addr == OFF_MAX2)
    begin
      // RULE_02 second maximum check
      wr_ok = st_reg.w_data[31:FW] == '0 && st_reg.w_data[FW-1:0] <= FREQ_LIM &&
        st_reg.w_data[FW-1:0] >= st_reg.base2;
    end
    else if (st_reg.aw_addr == OFF_SRC)
    begin
      wr_ok = st_reg.w_data >= 32'(SRC_V_KNOB) && st_reg.w_data <= 32'(SRC_I_ONLY);
    end
    else if (st_reg.aw_addr == OFF_VSF || st_reg.aw_addr == OFF_VEF ||
      st_reg.aw_addr == OFF_ISF || st_reg.aw_addr == OFF_IEF)
    begin
      // RULE_07 map frequency range
      wr_ok = st_reg.w_data <= 32'(FREQ_LIM);
    end
    else if (st_reg.aw_addr == OFF_VSP || st_reg.aw_addr == OFF_VEP ||
      st_reg.aw_addr == OFF_ISP || st_reg.aw_addr == OFF_IEP)
    begin
      wr_ok = st_reg.w_data <= 32'(PCT_MAX);
    end
    else if (st_reg.aw_addr == OFF_VLOW || st_reg.aw_addr == OFF_ILOW)
    begin
      wr_ok = st_reg.w_data <= 32'h0000_0001;
    end
    else if (st_reg.aw_addr == OFF_AVG)
    begin
      wr_ok = st_reg.w_data >= 32'(AVG_MIN) && st_reg.w_data <= 32'(AVG_MAX);
    end
    // Byte strobes are ignored: an accepted write always sets the whole field
    if (wr_go)
    begin
      st_next.aw_hold = 1'b0;
      st_next.w_hold = 1'b0;
      st_next.bvalid = 1'b1;
      st_next.bresp = wr_ok ? RESP_OKAY : RESP_SLVERR;
      if (wr_ok)
      begin
        case (st_reg.aw_addr)
          OFF_CTRL: st_next.set2 = st_reg.w_data[0];
          OFF_BASE1: st_next.base1 = st_reg.w_data[FW-1:0];
          OFF_MAX1: st_next.max1 = st_reg.w_data[FW-1:0];
          OFF_BASE2: st_next.base2 = st_reg.w_data[FW-1:0];
          OFF_MAX2: st_next.max2 = st_reg.w_data[FW-1:0];
          OFF_SRC: st_next.src = st_reg.w_data[2:0];
          OFF_VSF: st_next.vsf = st_reg.w_data[FW-1:0];
          OFF_VEF: st_next.vef = st_reg.w_data[FW-1:0];
          OFF_VSP: st_next.vsp = st_reg.w_data[PW-1:0];
          OFF_VEP: st_next.vep = st_reg.w_data[PW-1:0];
          OFF_VLOW: st_next.vlow = st_reg.w_data[0];
          OFF_AVG: st_next.avg_n = st_reg.w_data[CW-1:0];
          OFF_ISF: st_next.isf = st_reg.w_data[FW-1:0];
          OFF_IEF: st_next.ief = st_reg.w_data[FW-1:0];
          OFF_ISP: st_next.isp = st_reg.w_data[PW-1:0];
          OFF_IEP: st_next.iep = st_reg.w_data[PW-1:0];
          default: st_next.ilow = st_reg.w_data[0];
        endcase
        // A new count restarts the average so no stale partial sum is used
        if (st_reg.aw_addr == OFF_AVG)
        begin
          st_next.acc = '0;
          st_next.cnt = '0;
        end
      end
    end
    // ----------------------------------------
    // Read channel
    // ----------------------------------------
    rd_hit = 1'b1;
    rd_val = 32'h0000_0000;
    if (s_axi_araddr == OFF_CTRL) rd_val = 32'(st_reg.set2);
    else if (s_axi_araddr == OFF_BASE1) rd_val = 32'(st_reg.base1);
    else if (s_axi_araddr == OFF_MAX1) rd_val = 32'(st_reg.max1);
    else if (s_axi_araddr == OFF_BASE2) rd_val = 32'(st_reg.base2);
    else if (s_axi_araddr == OFF_MAX2) rd_val = 32'(st_reg.max2);
    else if (s_axi_araddr == OFF_SRC) rd_val = 32'(st_reg.src);
    else if (s_axi_araddr == OFF_VSF) rd_val = 32'(st_reg.vsf);
    else if (s_axi_araddr == OFF_VEF) rd_val = 32'(st_reg.vef);
    else if (s_axi_araddr == OFF_VSP) rd_val = 32'(st_reg.vsp);
    else if (s_axi_araddr == OFF_VEP) rd_val = 32'(st_reg.vep);
    else if (s_axi_araddr == OFF_VLOW) rd_val = 32'(st_reg.vlow);
    else if (s_axi_araddr == OFF_AVG) rd_val = 32'(st_reg.avg_n);
    else if (s_axi_araddr == OFF_ISF) rd_val = 32'(st_reg.isf);
    else if (s_axi_araddr == OFF_IEF) rd_val = 32'(st_reg.ief);
    else if (s_axi_araddr == OFF_ISP) rd_val = 32'(st_reg.isp);
    else if (s_axi_araddr == OFF_IEP) rd_val = 32'(st_reg.iep);
    else if (s_axi_araddr == OFF_ILOW) rd_val = 32'(st_reg.ilow);
    else if (s_axi_araddr == OFF_FREQ) rd_val = 32'(st_reg.freq);
    else if (s_axi_araddr == OFF_VOLT) rd_val = 32'(st_reg.volt);
    else rd_hit = 1'b0;
    if (st_reg.rvalid && s_axi_rready)
    begin
      st_next.rvalid = 1'b0;
    end
    if (s_axi_arvalid && !st_reg.rvalid)
    begin
      st_next.rvalid = 1'b1;
      st_next.rdata = rd_val;
      st_next.rresp = rd_hit ? RESP_OKAY : RESP_SLVERR;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st_reg <= '0;
      st_reg.base1 <= BASE_RST;
      st_reg.max1 <= MAX_RST;
      st_reg.base2 <= BASE_RST;
      st_reg.max2 <= MAX_RST;
      st_reg.src <= SRC_V_KNOB;
      st_reg.vep <= EP_RST;
      st_reg.iep <= EP_RST;
      st_reg.vlow <= LOW_RST;
      st_reg.ilow <= LOW_RST;
      st_reg.avg_n <= AVG_RST;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_wr_ready;
    st_reg.aw_hold && st_reg.w_hold && !st_reg.bvalid;
  endsequence
  sequence s_wr_done;
    ##1 (st_reg.bvalid && !st_reg.aw_hold && !st_reg.w_hold);
  endsequence

  chk_wr_answer: assert property (s_wr_ready |-> s_wr_done) // write response timing
    else $error("write response not raised one cycle after both halves held");
  chk_base_range: assert property (st_reg.base1 >= BASE_MIN && st_reg.base1 <= st_reg.max1) // RULE_01
    else $error("first base frequency out of range");
  chk_max_range: assert property (st_reg.max2 <= FREQ_LIM && st_reg.max2 >= st_reg.base2) // RULE_02
    else $error("second maximum frequency out of range");
  chk_map_freqs: assert property (st_reg.vef <= FREQ_LIM && st_reg.isf <= FREQ_LIM) // RULE_07
    else $error("map frequency above limit");
  chk_volt_ramp: assert property ($stable(st_reg.freq) && $stable(act_base) && // RULE_03
    st_reg.freq < act_base |->
    32'(st_reg.volt) * 32'(act_base) <= 32'(st_reg.freq) * 32'(VOLT_FULL))
    else $error("voltage above constant V/f line");
  chk_volt_full: assert property (st_reg.freq >= act_base && $stable(act_base)
    |=> st_reg.volt == VOLT_FULL) // RULE_04
    else $error("voltage not full scale above base");
  chk_one_src: assert property (st_reg.src == SRC_V_ONLY |-> pick == vmap) // RULE_05
    else $error("voltage-only selection used another source");
  chk_vin_low: assert property (32'(voltage_in_code) < 32'(st_reg.vsp) * 32'd10 && st_reg.vlow
    |-> vmap == 12'h000) // RULE_08
    else $error("voltage below start not at 0 Hz");
  chk_vin_high: assert property (32'(voltage_in_code) >= 32'(st_reg.vep) * 32'd10 &&
    32'(voltage_in_code) >= 32'(st_reg.vsp) * 32'd10 |-> vmap == st_reg.vef) // RULE_09
    else $error("voltage above end not at end frequency");
  chk_iin_low: assert property (32'(current_in_terminal) < 32'(st_reg.isp) * 32'd10 &&
    !st_reg.ilow |-> imap == st_reg.isf) // RULE_11
    else $error("current below start not at start frequency");
  chk_iin_high: assert property (32'(current_in_terminal) >= 32'(st_reg.iep) * 32'd10 &&
    32'(current_in_terminal) >= 32'(st_reg.isp) * 32'd10 |-> imap == st_reg.ief) // RULE_12
    else $error("current above end not at end frequency");
  chk_avg_count: assert property (st_reg.avg_n >= AVG_MIN && st_reg.avg_n <= AVG_MAX &&
    st_reg.cnt < st_reg.avg_n) // RULE_14
    else $error("average count out of range");
  chk_freq_clamp: assert property ($stable(act_max) |-> st_reg.freq <= act_max) // RULE_16
    else $error("frequency above active maximum");
  chk_set_pick: assert property (st_reg.set2 |-> act_max == st_reg.max2) // RULE_15
    else $error("second set selected but first maximum used");
endmodule
`default_nettype wire

// ===== sim/asrs_src_model.sv
// Model of the analog speed reference source feeding the scaler.
// Assumes one shared clock; levels hold between strobes like real inputs.
`timescale 1ns/1ps
`default_nettype none
module asrs_src_model
  import asrs_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic req,
  input wire logic [4:0] count,
  input wire logic [3:0] gap,
  input wire logic [XW-1:0] v_lvl,
  input wire logic [XW-1:0] i_lvl,
  input wire logic [XW-1:0] k_lvl,
  output logic sample_strobe,
  output logic [XW-1:0] voltage_in_code,
  output logic [XW-1:0] current_in_terminal,
  output logic [XW-1:0] front_knob,
  output logic busy
);
  logic [4:0] left;
  logic [3:0] timer;
  assign voltage_in_code = v_lvl;
  assign current_in_terminal = i_lvl;
  assign front_knob = k_lvl;
  assign busy = (left != 5'h00) || sample_strobe;
  // A nonzero gap plays a slow converter between samples
  always_ff @(posedge aclk)
  begin
    if (!aresetn || req)
    begin
      left <= aresetn ? count : 5'h00;
      timer <= 4'h0;
      sample_strobe <= 1'b0;
    end
    else if (left != 5'h00 && timer == 4'h0)
    begin
      sample_strobe <= 1'b1;
      left <= left - 5'h01;
      timer <= gap;
    end
    else
    begin
      sample_strobe <= 1'b0;
      if (timer != 4'h0) timer <= timer - 4'h1;
    end
  end
endmodule
`default_nettype wire

// ===== sim/asrs_top_tb_top.sv
// Self-checking bench for the analog speed reference scaler.
// Registers are reached over AXI4-Lite; samples come from the source model.
`timescale 1ns/1ps
`default_nettype none
module asrs_top_tb_top;
  import asrs_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0, rdata;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic req = 1'b0, pin = 1'b1, strobe, busy;
  logic [4:0] cnt = 5'h01;
  logic [3:0] gap = 4'h0;
  logic [XW-1:0] v_lvl = 10'h000, i_lvl = 10'h000, k_lvl = 10'h000, v_code, i_code, k_code;
  logic [FW-1:0] freq_cmd;
  logic [XW-1:0] volt_cmd;
  int errors = 0, comparisons = 0, cyc = 0;
  always #25 aclk = ~aclk;
  asrs_top asrs_top_inst (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .sample_strobe(strobe), .voltage_in_code(v_code), .current_in_terminal(i_code),
    .front_knob(k_code), .input_select_pin(pin), .freq_cmd(freq_cmd), .volt_cmd(volt_cmd));
  asrs_src_model asrs_src_model_inst (.aclk(aclk), .aresetn(aresetn), .req(req),
    .count(cnt), .gap(gap), .v_lvl(v_lvl), .i_lvl(i_lvl), .k_lvl(k_lvl),
    .sample_strobe(strobe), .voltage_in_code(v_code), .current_in_terminal(i_code),
    .front_knob(k_code), .busy(busy));
  // ----------------------------------------
  // Checking and closing
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    comparisons++;
    if (got !== exp)
    begin
      errors++;
      $display("[ERR] %0t %s got %0h expected %0h", $time, what, got, exp);
    end
  endtask
  task automatic end_of_test();
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // Ceiling well above the few hundred cycles the tests need
  always @(posedge aclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      errors++;
      $display("[ERR] %0t run hung", $time);
      end_of_test();
    end
  end
  // ----------------------------------------
  // Bus and sample tasks
  // ----------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ta, tw, tb;
    logic [1:0] r;
    tb = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!tb)
    begin
      @(negedge aclk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      tb = bvalid;
      r = bresp;
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
    end
    bready <= 1'b0;
    chk({30'h0, r}, {30'h0, er}, "write response");
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic ta, tr;
    logic [31:0] d;
    logic [1:0] r;
    tr = 1'b0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!tr)
    begin
      @(negedge aclk);
      ta = arvalid && arready;
      tr = rvalid;
      d = rdata;
      r = rresp;
      @(posedge aclk);
      if (ta) arvalid <= 1'b0;
    end
    rready <= 1'b0;
    chk(d, ed, "read data");
    chk({30'h0, r}, {30'h0, er}, "read response");
  endtask
  // Sends n samples at the given levels, then compares both commands
  task automatic smp(input logic [9:0] v, input logic [9:0] i, input logic [9:0] k,
      input logic [4:0] n, input logic [11:0] ef, input logic [9:0] ev);
    @(posedge aclk);
    v_lvl <= v;
    i_lvl <= i;
    k_lvl <= k;
    cnt <= n;
    repeat (4) @(posedge aclk);
    req <= 1'b1;
    @(posedge aclk);
    req <= 1'b0;
    @(posedge aclk);
    while (busy) @(posedge aclk);
    repeat (3) @(posedge aclk);
    chk({20'h0, freq_cmd}, {20'h0, ef}, "frequency command");
    chk({22'h0, volt_cmd}, {22'h0, ev}, "voltage command");
  endtask
  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial
  begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    rd(OFF_BASE1, 32'd500, RESP_OKAY);
    rd(OFF_AVG, 32'd8, RESP_OKAY);
    rd(8'h4C, 32'h0, RESP_SLVERR);
    wr(OFF_FREQ, 32'd5, RESP_SLVERR);
    wr(OFF_BASE1, 32'd299, RESP_SLVERR);
    wr(OFF_BASE1, 32'd501, RESP_SLVERR);
    wr(OFF_MAX1, 32'd4001, RESP_SLVERR);
    wr(OFF_MAX1, 32'd499, RESP_SLVERR);
    wr(OFF_MAX1, 32'd4000, RESP_OKAY);
    wr(OFF_VEF, 32'd4001, RESP_SLVERR);
    wr(OFF_AVG, 32'd18, RESP_SLVERR);
    wr(OFF_AVG, 32'd1, RESP_OKAY);
    wr(OFF_SRC, SRC_V_ONLY, RESP_OKAY);
    wr(OFF_VSF, 32'd100, RESP_OKAY);
    wr(OFF_VEF, 32'd3000, RESP_OKAY);
    wr(OFF_VSP, 32'd20, RESP_OKAY);
    wr(OFF_VEP, 32'd80, RESP_OKAY);
    smp(10'd500, 10'd0, 10'd0, 5'd1, 12'd1550, 10'd1000);
    smp(10'd100, 10'd0, 10'd0, 5'd1, 12'd0, 10'd0);
    wr(OFF_VLOW, 32'd0, RESP_OKAY);
    smp(10'd100, 10'd0, 10'd0, 5'd1, 12'd100, 10'd200);
    smp(10'd900, 10'd0, 10'd0, 5'd1, 12'd3000, 10'd1000);
    wr(OFF_SRC, SRC_I_ONLY, RESP_OKAY);
    wr(OFF_IEF, 32'd2000, RESP_OKAY);
    smp(10'd900, 10'd500, 10'd0, 5'd1, 12'd1000, 10'd1000);
    wr(OFF_ISF, 32'd400, RESP_OKAY);
    wr(OFF_ISP, 32'd50, RESP_OKAY);
    wr(OFF_IEP, 32'd60, RESP_OKAY);
    smp(10'd0, 10'd100, 10'd0, 5'd1, 12'd0, 10'd0);
    wr(OFF_ILOW, 32'd0, RESP_OKAY);
    smp(10'd0, 10'd100, 10'd0, 5'd1, 12'd400, 10'd800);
    smp(10'd0, 10'd900, 10'd0, 5'd1, 12'd2000, 10'd1000);
    pin <= 1'b0;
    for (int c = 2; c < 4; c++)
    begin
      wr(OFF_SRC, c, RESP_OKAY);
      smp(10'd900, 10'd900, 10'd250, 5'd1, 12'd1000, 10'd1000);
    end
    pin <= 1'b1;
    wr(OFF_SRC, SRC_V_KNOB, RESP_OKAY);
    smp(10'd500, 10'd0, 10'd0, 5'd1, 12'd1550, 10'd1000);
    gap <= 4'h3;
    wr(OFF_AVG, 32'd2, RESP_OKAY);
    smp(10'd100, 10'd0, 10'd0, 5'd1, 12'd1550, 10'd1000);
    smp(10'd900, 10'd0, 10'd0, 5'd1, 12'd1550, 10'd1000);
    wr(OFF_CTRL, 32'd1, RESP_OKAY);
    smp(10'd900, 10'd0, 10'd0, 5'd2, 12'd500, 10'd1000);
    rd(OFF_FREQ, 32'd500, RESP_OKAY);
    rd(OFF_VOLT, 32'd1000, RESP_OKAY);
    end_of_test();
  end
endmodule
`default_nettype wire
